// ### src/dcd_defs.svh
// constants of the display compression datapath: offsets, fields, reset values
// assumes one core display clock and an apb master with 32-bit data
//
// Notes on behaviour
// - the pixel stream is taken from one of three selectable input points
// - each engine takes one pixel per clock; the two engines share one pixel per clock between them
// - each engine is configured from its own parameter register copy
// - one control register; two copies of the parameter registers, one per engine
// - split streams: upper output is left (front), lower is right (back)
// - joiner output drives only the upper (left) output
// - bypass: all stages off, output on left only
// - compress-only: one engine on, output on left only
// - split-only: splitter on, no compression, output on both branches
// - split and compress: both engines on, compressed output on both branches
// - joiner mode: all stages on, left output only, never with multi-segment panels
// - no compression of interlaced timing, progressive frames only
// - first parameter register holds a double-buffer disable field
// - parameter registers hold slice rows per frame and slices per line
`ifndef DCD_DEFS_SVH
`define DCD_DEFS_SVH

`define DCD_PIX_W        30
`define DCD_ADDR_W       12

`define DCD_OFF_CTL      12'h000
`define DCD_OFF_STATUS   12'h004
`define DCD_OFF_BR0      12'h010
`define DCD_OFF_BR1      12'h020
`define DCD_SUB_SLICE    4'h0
`define DCD_SUB_PPS0     4'h4
`define DCD_SUB_PPS16    4'h8

`define DCD_CTL_SPLIT    0
`define DCD_CTL_COMP     1
`define DCD_CTL_JOIN     2
`define DCD_CTL_INSEL    4
`define DCD_CTL_MSO      8
`define DCD_CTL_HACT     16
`define DCD_CTL_MASK     32'hffff_0137

`define DCD_ST_UNSUP     8
`define DCD_ST_INTERL    9

`define DCD_PPS0_VBR     0
`define DCD_PPS0_DBDIS   1
`define DCD_PPS16_MASK   32'h0fff_00ff

`define DCD_CTL_RST      32'h0000_0000
`define DCD_SLICE_RST    16'h0012
`define DCD_PPS0_RST     2'h0
`define DCD_PPS16_RST    32'h0001_0001

`endif

// ### src/dcd_pkg.sv
// types of the display compression datapath
// assumes the constants header is on the include path
`include "dcd_defs.svh"

package dcd_pkg;

   typedef enum logic [5:0] {
      M_BYPASS    = 6'h01,
      M_COMP      = 6'h02,
      M_SPLIT     = 6'h04,
      M_SPLITCOMP = 6'h08,
      M_JOIN      = 6'h10,
      M_UNSUP     = 6'h20
   } dcd_mode_t;

   typedef struct packed {
      logic [15:0]            pos;
      logic                   outValid;
      logic [`DCD_PIX_W-1:0]  outData;
      logic                   outSliceEnd;
   } dcd_eng_st_t;

   typedef struct packed {
      logic [31:0]            ctl;
      logic [1:0][15:0]       slwPend;
      logic [1:0][15:0]       slwAct;
      logic [1:0][1:0]        pps0;
      logic [1:0][31:0]       pps16;
      logic [31:0]            prdata;
      dcd_mode_t              mode;
      logic [15:0]            xpos;
      logic                   rawValid;
      logic [`DCD_PIX_W-1:0]  rawData;
      logic                   rawLeft;
      logic                   lValid;
      logic [`DCD_PIX_W-1:0]  lData;
      logic                   lEnd;
      logic                   rValid;
      logic [`DCD_PIX_W-1:0]  rData;
      logic                   rEnd;
   } dcd_top_st_t;

   // mode from the three enables, panel kind and timing
   function automatic dcd_mode_t decodeMode(input logic splitEn, input logic compEn,
                                            input logic joinEn, input logic msoEn,
                                            input logic interl);
      dcd_mode_t m;
      m = M_UNSUP;
      if (compEn && interl)
         m = M_UNSUP;
      else if (!splitEn && !compEn && !joinEn)
         m = M_BYPASS;
      else if (!splitEn && compEn && !joinEn)
         m = M_COMP;
      else if (splitEn && !compEn && !joinEn)
         m = M_SPLIT;
      else if (splitEn && compEn && !joinEn)
         m = M_SPLITCOMP;
      else if (splitEn && compEn && joinEn && !msoEn)
         m = M_JOIN;
      return m;
   endfunction : decodeMode

endpackage : dcd_pkg

// ### src/dcd_engine.sv
// one compression branch, one pixel per clock, slice framing
// assumes pixels arrive on the core display clock with a line start mark
`timescale 1ns/1ps
`include "dcd_defs.svh"

module dcd_engine
   import dcd_pkg::*;
(
   input  wire logic                  clock,        // core display clock
   input  wire logic                  nrst,         // sync reset, low active
   input  wire logic                  ce,           // clock enable
   input  wire logic                  enable,       // branch compresses
   input  wire logic                  inValid,      // pixel present
   input  wire logic [`DCD_PIX_W-1:0] inData,       // pixel
   input  wire logic                  inStartLine,  // first pixel of a line
   input  wire logic [15:0]           sliceWidth,   // active slice width
   output logic                       outValid,     // coded word present
   output logic [`DCD_PIX_W-1:0]      outData,      // coded word
   output logic                       outSliceEnd   // last word of a slice
);

   dcd_eng_st_t st_q;
   dcd_eng_st_t st_d;

   // =========================================================
   // slice framing
   always_comb
   begin
      logic [15:0] posNow;
      logic        last;
      posNow = inStartLine ? 16'h0000 : st_q.pos;
      last   = (posNow == (sliceWidth - 16'h0001));
      st_d   = st_q;
      st_d.outValid    = 1'b0;
      st_d.outSliceEnd = 1'b0;
      if (!enable)
         st_d.pos = 16'h0000;
      else if (inValid)
      begin
         st_d.outValid    = 1'b1;
         st_d.outData     = inData;
         st_d.outSliceEnd = last;
         st_d.pos         = last ? 16'h0000 : posNow + 16'h0001;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
         st_q <= '0;
      else if (ce)
         st_q <= st_d;
   end

   assign outValid    = st_q.outValid;
   assign outData     = st_q.outData;
   assign outSliceEnd = st_q.outSliceEnd;

   // =========================================================
   // checks
   a_one_ppc: assert property (@(posedge clock) disable iff (!nrst)
      (ce && enable && inValid) |=> (outValid && outData == $past(inData)))
      else $error("engine dropped a pixel");

endmodule : dcd_engine

// ### src/dcd_top.sv
// display compression datapath: source select, splitter, two engines, joiner
// assumes upstream pipe and downstream port on the same core display clock
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "dcd_defs.svh"

module dcd_top
   import dcd_pkg::*;
(
   input  wire logic                  clock,          // core display clock
   input  wire logic                  nrst,           // sync reset, low active
   input  wire logic                  ce,             // clock enable
   input  wire logic                  psel,           // apb select
   input  wire logic                  penable,        // apb access phase
   input  wire logic                  pwrite,         // apb write
   input  wire logic [`DCD_ADDR_W-1:0] paddr,         // apb byte address
   input  wire logic [31:0]           pwdata,         // apb write data
   output logic [31:0]                prdata,         // apb read data
   output logic                       pready,         // apb ready
   output logic                       pslverr,        // apb error
   input  wire logic                  src0Valid,      // input point 0 pixel
   input  wire logic [`DCD_PIX_W-1:0] src0Data,       // input point 0 data
   input  wire logic                  src1Valid,      // input point 1 pixel
   input  wire logic [`DCD_PIX_W-1:0] src1Data,       // input point 1 data
   input  wire logic                  src2Valid,      // input point 2 pixel
   input  wire logic [`DCD_PIX_W-1:0] src2Data,       // input point 2 data
   input  wire logic                  srcStartLine,   // first pixel of a line
   input  wire logic                  vblankStart,    // vertical blank pulse
   input  wire logic                  interlacedTiming, // pipe runs interlaced
   output logic                       leftValid,      // left (front) pixel
   output logic [`DCD_PIX_W-1:0]      leftData,       // left data
   output logic                       leftSliceEnd,   // left slice end
   output logic                       rightValid,     // right (back) pixel
   output logic [`DCD_PIX_W-1:0]      rightData,      // right data
   output logic                       rightSliceEnd   // right slice end
);

   dcd_top_st_t st_q;
   dcd_top_st_t st_d;

   logic                  selValid;
   logic [`DCD_PIX_W-1:0] selData;
   logic [1:0]            inSel;
   logic [15:0]           xNow;
   logic [15:0]           hAct;
   logic                  onLeft;
   logic                  splitOn;
   logic                  compOn;
   logic                  engLIn;
   logic                  engRIn;
   logic                  engLValid;
   logic [`DCD_PIX_W-1:0] engLData;
   logic                  engLEnd;
   logic                  engRValid;
   logic [`DCD_PIX_W-1:0] engRData;
   logic                  engREnd;
   logic                  apbWr;
   logic                  apbSetup;

   // apb address is mapped
   function automatic logic regHit(input logic [`DCD_ADDR_W-1:0] a);
      logic br;
      br = (a[11:4] == `DCD_OFF_BR0 >> 4) || (a[11:4] == `DCD_OFF_BR1 >> 4);
      return (a == `DCD_OFF_CTL) || (a == `DCD_OFF_STATUS) ||
             (br && (a[3:0] == `DCD_SUB_SLICE || a[3:0] == `DCD_SUB_PPS0 ||
                     a[3:0] == `DCD_SUB_PPS16));
   endfunction : regHit

   // branch base of copy b
   function automatic logic [`DCD_ADDR_W-1:0] brBase(input int b);
      return (b == 0) ? `DCD_OFF_BR0 : `DCD_OFF_BR1;
   endfunction : brBase

   // =========================================================
   // source select and splitter
   assign inSel = st_q.ctl[`DCD_CTL_INSEL+1:`DCD_CTL_INSEL];
   assign hAct  = st_q.ctl[`DCD_CTL_HACT+15:`DCD_CTL_HACT];

   always_comb
   begin
      selValid = 1'b0;
      selData  = '0;
      case (inSel)
         2'd0:
         begin
            selValid = src0Valid;
            selData  = src0Data;
         end
         2'd1:
         begin
            selValid = src1Valid;
            selData  = src1Data;
         end
         2'd2:
         begin
            selValid = src2Valid;
            selData  = src2Data;
         end
         default:
         begin
            selValid = 1'b0;
            selData  = '0;
         end
      endcase
   end

   assign xNow    = srcStartLine ? 16'h0000 : st_q.xpos;
   assign onLeft  = xNow < (hAct >> 1);
   assign splitOn = (st_q.mode == M_SPLIT) || (st_q.mode == M_SPLITCOMP) ||
                    (st_q.mode == M_JOIN);
   assign compOn  = (st_q.mode == M_COMP) || (st_q.mode == M_SPLITCOMP) ||
                    (st_q.mode == M_JOIN);
   assign engLIn  = selValid && compOn && (!splitOn || onLeft);
   assign engRIn  = selValid && compOn && splitOn && !onLeft;

   // =========================================================
   // engines, each on its own parameter copy
   dcd_engine u_engLeft (
      .clock       (clock),
      .nrst        (nrst),
      .ce          (ce),
      .enable      (compOn),
      .inValid     (engLIn),
      .inData      (selData),
      .inStartLine (srcStartLine),
      .sliceWidth  (st_q.slwAct[0]),
      .outValid    (engLValid),
      .outData     (engLData),
      .outSliceEnd (engLEnd)
   );

   dcd_engine u_engRight (
      .clock       (clock),
      .nrst        (nrst),
      .ce          (ce),
      .enable      (compOn && splitOn),
      .inValid     (engRIn),
      .inData      (selData),
      .inStartLine (engRIn && xNow == (hAct >> 1)),
      .sliceWidth  (st_q.slwAct[1]),
      .outValid    (engRValid),
      .outData     (engRData),
      .outSliceEnd (engREnd)
   );

   // =========================================================
   // apb slave
   assign apbSetup = psel && !penable;
   assign apbWr    = psel && penable && pwrite && ce;
   assign pready   = psel && penable && ce;
   assign pslverr  = psel && penable && ce && !regHit(paddr);
   assign prdata   = st_q.prdata;

   // =========================================================
   // next state
   always_comb
   begin
      st_d = st_q;
      st_d.mode = decodeMode(st_q.ctl[`DCD_CTL_SPLIT], st_q.ctl[`DCD_CTL_COMP],
                             st_q.ctl[`DCD_CTL_JOIN], st_q.ctl[`DCD_CTL_MSO],
                             interlacedTiming);
      if (apbWr && paddr == `DCD_OFF_CTL)
         st_d.ctl = pwdata & `DCD_CTL_MASK;
      for (int b = 0; b < 2; b++)
      begin
         if (apbWr && paddr == brBase(b) + {8'h00, `DCD_SUB_SLICE})
            st_d.slwPend[b] = pwdata[15:0];
         if (apbWr && paddr == brBase(b) + {8'h00, `DCD_SUB_PPS0})
            st_d.pps0[b] = pwdata[1:0];
         if (apbWr && paddr == brBase(b) + {8'h00, `DCD_SUB_PPS16})
            st_d.pps16[b] = pwdata & `DCD_PPS16_MASK;
         if (vblankStart || st_q.pps0[b][`DCD_PPS0_DBDIS])
            st_d.slwAct[b] = st_q.slwPend[b];
      end
      if (apbSetup)
      begin
         st_d.prdata = 32'h0000_0000;
         for (int b = 0; b < 2; b++)
         begin
            if (paddr == brBase(b) + {8'h00, `DCD_SUB_SLICE})
               st_d.prdata = {16'h0000, st_q.slwPend[b]};
            if (paddr == brBase(b) + {8'h00, `DCD_SUB_PPS0})
               st_d.prdata = {30'h0000_0000, st_q.pps0[b]};
            if (paddr == brBase(b) + {8'h00, `DCD_SUB_PPS16})
               st_d.prdata = st_q.pps16[b];
         end
         if (paddr == `DCD_OFF_CTL)
            st_d.prdata = st_q.ctl;
         if (paddr == `DCD_OFF_STATUS)
         begin
            st_d.prdata[5:0]           = st_q.mode;
            st_d.prdata[`DCD_ST_UNSUP]  = (st_q.mode == M_UNSUP);
            st_d.prdata[`DCD_ST_INTERL] = interlacedTiming && st_q.ctl[`DCD_CTL_COMP];
         end
      end
      if (selValid)
         st_d.xpos = xNow + 16'h0001;
      st_d.rawValid = selValid && (st_q.mode != M_UNSUP);
      st_d.rawData  = selData;
      st_d.rawLeft  = !splitOn || onLeft;
      st_d.lValid = 1'b0;
      st_d.lEnd   = 1'b0;
      st_d.rValid = 1'b0;
      st_d.rEnd   = 1'b0;
      case (st_q.mode)
         M_BYPASS:
         begin
            st_d.lValid = st_q.rawValid;
            st_d.lData  = st_q.rawData;
         end
         M_COMP:
         begin
            st_d.lValid = engLValid;
            st_d.lData  = engLData;
            st_d.lEnd   = engLEnd;
         end
         M_SPLIT:
         begin
            st_d.lValid = st_q.rawValid && st_q.rawLeft;
            st_d.lData  = st_q.rawData;
            st_d.rValid = st_q.rawValid && !st_q.rawLeft;
            st_d.rData  = st_q.rawData;
         end
         M_SPLITCOMP:
         begin
            st_d.lValid = engLValid;
            st_d.lData  = engLData;
            st_d.lEnd   = engLEnd;
            st_d.rValid = engRValid;
            st_d.rData  = engRData;
            st_d.rEnd   = engREnd;
         end
         M_JOIN:
         begin
            st_d.lValid = engLValid || engRValid;
            st_d.lData  = engLValid ? engLData : engRData;
            st_d.lEnd   = engLValid ? engLEnd : engREnd;
         end
         default:
         begin
            st_d.lValid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         st_q         <= '0;
         st_q.ctl     <= `DCD_CTL_RST;
         st_q.slwPend <= {2{`DCD_SLICE_RST}};
         st_q.slwAct  <= {2{`DCD_SLICE_RST}};
         st_q.pps0    <= {2{`DCD_PPS0_RST}};
         st_q.pps16   <= {2{`DCD_PPS16_RST}};
         st_q.mode    <= M_BYPASS;
      end
      else if (ce)
         st_q <= st_d;
   end

   assign leftValid     = st_q.lValid;
   assign leftData      = st_q.lData;
   assign leftSliceEnd  = st_q.lEnd;
   assign rightValid    = st_q.rValid;
   assign rightData     = st_q.rData;
   assign rightSliceEnd = st_q.rEnd;

   // =========================================================
   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence s_bypassIn;
      ce && st_q.mode == M_BYPASS && selValid;
   endsequence

   sequence s_bypassHold;
      ce && st_q.mode == M_BYPASS;
   endsequence

   a_src_to_left: assert property (s_bypassIn ##1 s_bypassHold |=>
      (leftValid && leftData == $past(selData, 2)))
      else $error("selected input did not reach left output");

   a_bypass_right: assert property (s_bypassIn ##1 s_bypassHold |=>
      !rightValid)
      else $error("bypass drove the right output");

   a_join_left_only: assert property (ce && st_q.mode == M_JOIN && engRValid
      |=> (leftValid && leftData == $past(engRData) && !rightValid))
      else $error("joined stream not on left only");

   a_join_no_mso: assert property ((ce && st_q.ctl[`DCD_CTL_JOIN] &&
      st_q.ctl[`DCD_CTL_MSO]) |=> st_q.mode != M_JOIN)
      else $error("joiner active with multi-segment panel");

   a_split_right: assert property (ce && st_q.mode == M_SPLITCOMP && engRValid
      |=> (rightValid && rightData == $past(engRData)))
      else $error("right branch lost a compressed word");

   a_split_raw: assert property (ce && st_q.mode == M_SPLIT && st_q.rawValid
      && !st_q.rawLeft |=> (rightValid && !leftValid))
      else $error("split pixel on wrong branch");

   a_no_interlace: assert property ((ce && interlacedTiming &&
      st_q.ctl[`DCD_CTL_COMP]) ##1 ce |=> !leftValid && !rightValid)
      else $error("interlaced stream was compressed");

   a_right_idle: assert property (ce && (st_q.mode inside {M_BYPASS, M_COMP,
      M_JOIN, M_UNSUP}) |=> !rightValid)
      else $error("right output active in single branch mode");

   a_dbuf_disable: assert property ((ce && st_q.pps0[0][`DCD_PPS0_DBDIS])
      |=> st_q.slwAct[0] == $past(st_q.slwPend[0]))
      else $error("double buffer disable did not pass update");

   a_copies_apart: assert property (apbWr && paddr[11:4] == (`DCD_OFF_BR1 >> 4)
      |=> $stable(st_q.slwPend[0]) && $stable(st_q.pps0[0]))
      else $error("write to second copy changed the first");

endmodule : dcd_top

// ### testbench/dcd_port_model.sv
// downstream port model: tallies words and keeps the last word per branch
// assumes registered branch outputs on the core display clock
`timescale 1ns/1ps
`include "dcd_defs.svh"

module dcd_port_model
(
   input  wire logic                  clock,      // core display clock
   input  wire logic                  clr,        // clears the tallies
   input  wire logic                  leftValid,  // left word present
   input  wire logic [`DCD_PIX_W-1:0] leftData,   // left word
   input  wire logic                  rightValid, // right word present
   input  wire logic [`DCD_PIX_W-1:0] rightData,  // right word
   input  wire logic                  leftEnd,    // left slice end
   input  wire logic                  rightEnd,   // right slice end
   output logic [7:0]                 leftCnt,    // left words seen
   output logic [7:0]                 rightCnt,   // right words seen
   output logic [7:0]                 endCnt,     // slice ends seen
   output logic [`DCD_PIX_W-1:0]      leftLast,   // last left word
   output logic [`DCD_PIX_W-1:0]      rightLast   // last right word
);
   // ==========================================
   // tallies, one word per cycle per branch
   always_ff @(posedge clock)
   begin
      if (clr)
      begin
         leftCnt  <= 8'h00;
         rightCnt <= 8'h00;
         endCnt   <= 8'h00;
      end
      else
      begin
         if ((leftValid && leftEnd) || (rightValid && rightEnd))
            endCnt <= endCnt + 8'h01;
         if (leftValid !== 1'b0)
         begin
            leftCnt  <= leftCnt + 8'h01;
            leftLast <= leftData;
         end
         if (rightValid !== 1'b0)
         begin
            rightCnt  <= rightCnt + 8'h01;
            rightLast <= rightData;
         end
      end
   end
endmodule : dcd_port_model

// ### testbench/display_compression_datapath_bench.sv
// bench of the compression datapath: apb master, pixel source, port model
// assumes zero-wait apb and a two-cycle pixel path
`timescale 1ns/1ps
`include "dcd_defs.svh"

module display_compression_datapath_bench;
   // ==========================================
   // signals
   logic        clock = 1'b0, nrst = 1'b0, clr = 1'b0, sol = 1'b0, vbl = 1'b0, intl = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, ce = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [2:0]  srcV = 3'h0;
   logic [29:0] pixD = 30'h0, lD, rD, lLast, rLast;
   logic        lV, lE, rV, rE;
   logic [7:0]  lCnt, rCnt, eCnt;
   int          mismatches = 0, num_checks = 0, cyc = 0;
   localparam logic [11:0] PPS0 = `DCD_OFF_BR0 + 12'h4, PPS16 = `DCD_OFF_BR0 + 12'h8;

   always #12.5 clock = ~clock;

   dcd_top dcd_top_i (.clock(clock), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src0Valid(srcV[0]), .src0Data(pixD), .src1Valid(srcV[1]),
      .src1Data(pixD ^ 30'h1), .src2Valid(srcV[2]), .src2Data(pixD ^ 30'h2),
      .srcStartLine(sol), .vblankStart(vbl), .interlacedTiming(intl), .leftValid(lV),
      .leftData(lD), .leftSliceEnd(lE), .rightValid(rV), .rightData(rD), .rightSliceEnd(rE));
   dcd_port_model dcd_port_model_i (.clock(clock), .clr(clr), .leftValid(lV), .leftData(lD),
      .rightValid(rV), .rightData(rD), .leftEnd(lE), .rightEnd(rE), .leftCnt(lCnt),
      .rightCnt(rCnt), .endCnt(eCnt), .leftLast(lLast), .rightLast(rLast));

   // ==========================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk

   task automatic send(input logic [2:0] m, input int n, input logic [29:0] base);
      @(posedge clock);
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         @(posedge clock);
         srcV <= m; pixD <= base + 30'(i); sol <= (i == 0);
      end
      @(posedge clock);
      srcV <= 3'h0; sol <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : send

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   // ==========================================
   // scenarios
   task automatic t_regs();
      rdchk(`DCD_OFF_CTL, 32'h0);
      rdchk(`DCD_OFF_STATUS, 32'h1);
      rdchk(`DCD_OFF_BR1, 32'h12);
      apb(1'b1, `DCD_OFF_BR0, 32'h24);
      apb(1'b1, `DCD_OFF_BR1, 32'h30);
      @(posedge clock) vbl <= 1'b1;
      @(posedge clock) vbl <= 1'b0;
      rdchk(`DCD_OFF_BR0, 32'h24);
      rdchk(`DCD_OFF_BR1, 32'h30);
      apb(1'b1, PPS0, 32'h2);
      rdchk(PPS0, 32'h2);
      rdchk(`DCD_OFF_BR1 + 12'h4, 32'h0);
      apb(1'b1, PPS16, 32'hf001ff02);
      rdchk(PPS16, 32'h00010002);
      rdchk(`DCD_OFF_BR1 + 12'h8, 32'h00010001);
      apb(1'b0, 12'h100, 32'h0);
      chk({31'h0, err}, 32'h1);
   endtask : t_regs

   task automatic t_modes();
      logic [31:0] mc [7] = '{32'h0, 32'h2, 32'h1, 32'h3, 32'h7, 32'h4, 32'h107};
      logic [31:0] ms [7] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h120, 32'h120};
      int          ml [7] = '{4, 4, 2, 2, 4, 0, 0};
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b1, `DCD_OFF_CTL, mc[i] | 32'h0004_0000);
         rdchk(`DCD_OFF_STATUS, ms[i]);
         send(3'h1, 4, 30'(256 * i));
         chk(lCnt, ml[i]);
         chk(rCnt, (ml[i] == 2) ? 2 : 0);
         chk(eCnt, 32'h0);
         if (i < 5)
            chk(lLast, 30'h100 * i + ((ml[i] == 2) ? 1 : 3));
         if (ml[i] == 2)
            chk(rLast, 30'h100 * i + 3);
      end
   endtask : t_modes

   task automatic t_source();
      for (int k = 0; k < 4; k++)
      begin
         apb(1'b1, `DCD_OFF_CTL, 32'(k) << 4);
         send(3'h7, 2, 30'h200);
         chk(lCnt, (k < 3) ? 2 : 0);
         if (k < 3)
            chk(lLast, 30'h201 ^ 30'(k));
      end
      intl <= 1'b1;
      apb(1'b1, `DCD_OFF_CTL, 32'h2);
      rdchk(`DCD_OFF_STATUS, 32'h320);
      send(3'h1, 2, 30'h300);
      chk(lCnt, 0);
      intl <= 1'b0;
   endtask : t_source

   task automatic t_slice();
      apb(1'b1, `DCD_OFF_BR0, 32'h12);
      apb(1'b1, `DCD_OFF_CTL, 32'h2);
      send(3'h1, 18, 30'h500);
      chk(lCnt, 32'd18);
      chk(eCnt, 32'h1);
      chk(lLast, 30'h511);
      apb(1'b1, `DCD_OFF_CTL, 32'h0);
      ce <= 1'b0;
      send(3'h1, 2, 30'h600);
      chk(lCnt, 32'h0);
      ce <= 1'b1;
   endtask : t_slice

   // ==========================================
   // main sequence and timeout
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         mismatches++;
         give_verdict();
      end
   end

   initial
   begin
      repeat (16) @(posedge clock);
      nrst <= 1'b1;
      t_regs();
      t_modes();
      t_source();
      t_slice();
      give_verdict();
   end
endmodule : display_compression_datapath_bench
